/* core/css_seq.sv */
// Charge state sequencer with per-cycle PWM latch
`timescale 1ns/1ns
`include "css_regs.svh"

// ==========================================================================
// Overview of operation
// R01: Below cutoff, hold trickle state and command the small trickle limit.
// R02: From trickle, move to bulk once voltage reaches cutoff.
// R03: Above cutoff at cycle start, skip trickle and enter bulk.
// R04: Exactly four states, chosen from sensed battery condition.
// R05: Bulk commands maximum current; leaves for over-charge at over-charge volts.
// R06: Over-charge regulates voltage instead of limiting current.
// R07: Over-charge goes to float when current falls to taper threshold.
// R08: Taper threshold is set outside, usually one fifth of bulk limit.
// R09: Float regulates a temperature-compensated constant voltage.
// R10: Float supplies load current but never above the bulk limit.
// R11: Float returns to bulk when voltage drops to 90% of float.
// R12: Current state always shown on status outputs.
// R13: Outside logic decodes the two status bits into a display.
// R14: Clock sets the PWM latch; sawtooth-above-control comparator resets.
// R15: State is clocked, inputs synchronised, one change per cycle.
// R16: Lockout holds state in reset, drive off, restart from initial.
module css_seq
    import css_pkg::*;
#(
    parameter int PWM_PERIOD_CYC = `CSS_PWM_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic uvlo,
    input wire logic above_cutoff,
    input wire logic overcharge_voltage_threshold,
    input wire logic below_float_90,
    input wire logic taper_current_threshold,
    input wire logic ramp_above_ctrl,
    output logic drive_out,
    output logic ilim_bulk_out,
    output logic volt_reg_out,
    output logic state_code_bit0_out,
    output logic state_code_bit1_out,
    output logic low_voltage_status_out
);
    localparam int CW = $clog2(PWM_PERIOD_CYC + 1);

    // ======================================================================
    // Input synchronisation
    css_cmp_s cmp_raw;
    css_cmp_s cmp;
    logic ramp_sync;
    logic [4:0] sync_q;

    assign cmp_raw = '{above_cutoff: above_cutoff,
                       at_overcharge: overcharge_voltage_threshold,
                       below_float_90: below_float_90,
                       at_taper: taper_current_threshold};

    css_sync #(.WIDTH(5)) u_sync (
        .clk(clk),
        .srst(srst),
        .d({ramp_above_ctrl, cmp_raw}),
        .q(sync_q)
    ); // see R15

    assign cmp = css_cmp_s'(sync_q[3:0]);
    assign ramp_sync = sync_q[4];

    // ======================================================================
    // Charge state register
    css_state_e state_q;
    css_state_e state_d;
    logic start_q;
    logic hold;
    logic [1:0] flush_q;
    logic settled;

    assign hold = srst | uvlo;

    // Synchroniser flops hold zeros for two edges after srst; the start
    // decision waits for them instead of reading a false low battery
    always_ff @(posedge clk) begin
        if (srst) begin
            flush_q <= `CSS_SYNC_FLUSH_CYC;
        end else if (flush_q != 2'h0) begin
            flush_q <= flush_q - 2'h1;
        end
    end

    assign settled = (flush_q == 2'h0);

    // Start flag marks the first valid evaluation after reset or lockout
    always_ff @(posedge clk) begin
        if (hold) begin
            start_q <= 1'b1; // see R16
        end else if (settled) begin
            start_q <= 1'b0;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            CSS_ST_TRICKLE: begin
                if (start_q && !settled) begin
                    // Synchronised levels not valid yet: stay put
                    state_d = CSS_ST_TRICKLE;
                end else if (start_q && cmp.above_cutoff) begin
                    state_d = CSS_ST_BULK; // see R03
                end else if (cmp.above_cutoff) begin
                    state_d = CSS_ST_BULK; // see R02
                end else begin
                    state_d = CSS_ST_TRICKLE; // see R01
                end
            end
            CSS_ST_BULK: begin
                if (cmp.at_overcharge) begin
                    state_d = CSS_ST_OVERCHARGE; // see R05
                end
            end
            CSS_ST_OVERCHARGE: begin
                if (cmp.at_taper) begin
                    state_d = CSS_ST_FLOAT; // see R07, R08
                end
            end
            CSS_ST_FLOAT: begin
                if (cmp.below_float_90) begin
                    state_d = CSS_ST_BULK; // see R11
                end
            end
            default: begin
                state_d = CSS_ST_TRICKLE;
            end
        endcase
    end

    // One transition per clock at most; lockout forces the initial state
    always_ff @(posedge clk) begin
        if (hold) begin
            state_q <= CSS_ST_TRICKLE; // see R16
        end else begin
            state_q <= state_d; // see R04, R15
        end
    end

    // ======================================================================
    // Status and power stage commands
    function automatic logic [1:0] css_code(input css_state_e st);
        case (st)
            CSS_ST_TRICKLE: css_code = `CSS_CODE_TRICKLE;
            CSS_ST_BULK: css_code = `CSS_CODE_BULK;
            CSS_ST_OVERCHARGE: css_code = `CSS_CODE_OVERCHARGE;
            CSS_ST_FLOAT: css_code = `CSS_CODE_FLOAT;
            default: css_code = `CSS_CODE_TRICKLE;
        endcase
    endfunction

    function automatic css_cmd_s css_cmd(input css_state_e st);
        css_cmd = '{ilim_bulk: `CSS_ILIM_BULK, volt_reg: 1'b0};
        case (st)
            CSS_ST_TRICKLE: css_cmd.ilim_bulk = `CSS_ILIM_TRICKLE; // see R01
            CSS_ST_BULK: css_cmd.volt_reg = 1'b0; // see R05
            // Voltage loop rules, current clamp stays at bulk level
            CSS_ST_OVERCHARGE: css_cmd.volt_reg = 1'b1; // see R06
            CSS_ST_FLOAT: css_cmd.volt_reg = 1'b1; // see R09, R10
            default: css_cmd.ilim_bulk = `CSS_ILIM_TRICKLE;
        endcase
    endfunction

    css_cmd_s cmd_d;
    logic [1:0] code_d;
    assign cmd_d = css_cmd(state_d);
    assign code_d = css_code(state_d);

    // Outputs registered from the next state so they track state_q exactly
    always_ff @(posedge clk) begin
        if (hold) begin
            state_code_bit0_out <= 1'b0;
            state_code_bit1_out <= 1'b0;
            low_voltage_status_out <= 1'b1;
        end else begin
            state_code_bit0_out <= code_d[0]; // see R12
            state_code_bit1_out <= code_d[1]; // see R12
            low_voltage_status_out <= (state_d == CSS_ST_TRICKLE);
        end
    end

    // Power stage commands: lockout falls back to the small trickle limit
    always_ff @(posedge clk) begin
        if (hold) begin
            ilim_bulk_out <= `CSS_ILIM_TRICKLE;
            volt_reg_out <= 1'b0;
        end else begin
            ilim_bulk_out <= cmd_d.ilim_bulk;
            volt_reg_out <= cmd_d.volt_reg;
        end
    end

    // ======================================================================
    // PWM oscillator and latch
    logic [CW-1:0] cnt_q;
    logic tick;

    assign tick = (cnt_q == CW'(PWM_PERIOD_CYC - 1));

    always_ff @(posedge clk) begin
        if (hold) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Reset by the comparator wins within a cycle except on the set edge;
    // the set takes priority so each period begins with a pulse
    always_ff @(posedge clk) begin
        if (hold) begin
            drive_out <= 1'b0; // see R16
        end else if (tick) begin
            drive_out <= 1'b1; // see R14
        end else if (ramp_sync) begin
            drive_out <= 1'b0; // see R14
        end
    end

endmodule

/* core/css_regs.svh */
// Constants for the charge state sequencer: state codes and cycle counts
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH

// ==========================================================================
// Status code per charging state (two status bits)
`define CSS_CODE_TRICKLE 2'h0
`define CSS_CODE_BULK 2'h1
`define CSS_CODE_OVERCHARGE 2'h2
`define CSS_CODE_FLOAT 2'h3

// ==========================================================================
// Current limit selection codes
`define CSS_ILIM_TRICKLE 1'h0
`define CSS_ILIM_BULK 1'h1

// ==========================================================================
// Switching period: time in ns and derived cycles at 100 MHz
`define CSS_CLK_PERIOD_NS 10
`define CSS_PWM_PERIOD_NS 10000
`define CSS_PWM_PERIOD_CYC (`CSS_PWM_PERIOD_NS / `CSS_CLK_PERIOD_NS)

// ==========================================================================
// Edges the two-flop synchroniser needs to flush after srst
`define CSS_SYNC_FLUSH_CYC 2'h2

`endif

/* core/css_pkg.sv */
// Types shared by the charge state sequencer files
package css_pkg;

    typedef enum logic [1:0] {
        CSS_ST_TRICKLE = 2'b00,
        CSS_ST_BULK = 2'b01,
        CSS_ST_OVERCHARGE = 2'b10,
        CSS_ST_FLOAT = 2'b11
    } css_state_e;

    // Comparator decisions from the analog front end
    typedef struct packed {
        logic above_cutoff;
        logic at_overcharge;
        logic below_float_90;
        logic at_taper;
    } css_cmp_s;

    // Commands to the power stage
    typedef struct packed {
        logic ilim_bulk;
        logic volt_reg;
    } css_cmd_s;

endpackage

/* core/css_sync.sv */
// Two-flop synchroniser for a bus of comparator levels
`timescale 1ns/1ns
module css_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

/* testbench/css_seq_monitor.sv */
// Port checker for the charge state sequencer
`timescale 1ns/1ns
module css_seq_monitor
    import css_pkg::*;
#(
    parameter int PWM_PERIOD_CYC = 1000
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic uvlo,
    input wire logic above_cutoff,
    input wire logic overcharge_voltage_threshold,
    input wire logic below_float_90,
    input wire logic taper_current_threshold,
    input wire logic ramp_above_ctrl,
    input wire logic drive_out,
    input wire logic ilim_bulk_out,
    input wire logic volt_reg_out,
    input wire logic state_code_bit0_out,
    input wire logic state_code_bit1_out,
    input wire logic low_voltage_status_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire logic [1:0] code = {state_code_bit1_out, state_code_bit0_out};
    // =====================================================================
    // Mode outputs follow the state code
    chk_mode_flags: assert property (
        {ilim_bulk_out, volt_reg_out, low_voltage_status_out}
        == {code != 2'h0, code[1], code == 2'h0}) else $error("mode flags");
    chk_step_order: assert property (
        !uvlo && !$past(uvlo) && code != $past(code) |->
        code == $past(code) + 2'h1 || code == 2'h1) else $error("order");
    // Four samples cover the two synchroniser flops and the state update
    chk_cut_bulk: assert property (
        (above_cutoff && !uvlo)[*4] |-> code != 2'h0) else $error("cut");
    chk_bulk_oc: assert property (
        (overcharge_voltage_threshold && !uvlo)[*4] ##0 $past(code) == 2'h1
        |-> code == 2'h2) else $error("bulk exit");
    chk_oc_float: assert property (
        (taper_current_threshold && !uvlo)[*4] ##0 $past(code) == 2'h2
        |-> code == 2'h3) else $error("taper exit");
    chk_float_bulk: assert property (
        (below_float_90 && !uvlo)[*4] ##0 $past(code) == 2'h3
        |-> code == 2'h1) else $error("float exit");
    chk_lockout_off: assert property (
        uvlo |=> !drive_out && code == 2'h0) else $error("lockout");
    chk_ramp_clear: assert property (
        ramp_above_ctrl[*5] |-> !drive_out || $rose(drive_out))
        else $error("latch clear");
    // Bench runs with a period of 8, so seven quiet edges follow a set
    chk_set_period: assert property (
        $rose(drive_out) |=> (!$rose(drive_out))[*7]) else $error("period");
endmodule

/* testbench/css_plant.sv */
// Power stage model: sawtooth that restarts at each turn-on
`timescale 1ns/1ns
module css_plant (
    input wire logic clk,
    input wire logic drive_out,
    input wire logic [3:0] ctrl_level,
    output logic ramp_above_ctrl
);
    logic [3:0] ramp_q;
    always_ff @(posedge clk) begin
        ramp_q <= drive_out ? ramp_q + 4'h1 : 4'h0;
    end
    assign ramp_above_ctrl = (ramp_q >= ctrl_level);
endmodule

/* testbench/charge_state_sequencer_test.sv */
// Self-checking bench for the charge state sequencer
`timescale 1ns/1ns
module charge_state_sequencer_test;
    import css_pkg::*;
    localparam logic [7:0] TRK = 8'h01, BLK = 8'h0c, OVC = 8'h16;
    localparam logic [7:0] FLT = 8'h1e;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic uvlo = 1'b0;
    css_cmp_s cmp = '0;
    logic [3:0] level = 4'h2;
    logic ramp, drive, ilim, vreg, b0, b1, lv;
    int miscompares = 0;
    int checked = 0;
    always #5 clk = ~clk;
    css_seq #(.PWM_PERIOD_CYC(8)) uut (.clk(clk), .srst(srst), .uvlo(uvlo),
        .above_cutoff(cmp.above_cutoff), .below_float_90(cmp.below_float_90),
        .overcharge_voltage_threshold(cmp.at_overcharge),
        .taper_current_threshold(cmp.at_taper), .ramp_above_ctrl(ramp),
        .drive_out(drive), .ilim_bulk_out(ilim), .volt_reg_out(vreg),
        .state_code_bit0_out(b0), .state_code_bit1_out(b1),
        .low_voltage_status_out(lv));
    css_plant plant (.clk(clk), .drive_out(drive), .ctrl_level(level),
        .ramp_above_ctrl(ramp));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Outside logic would decode the two code bits; the bench packs them
    function automatic logic [7:0] st();
        return {3'h0, b1, b0, ilim, vreg, lv};
    endfunction
    task automatic check(input string name, input logic [7:0] e, got);
        checked++;
        if (got !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, e, got);
        end
    endtask
    task automatic t_reset;
        step(1);
        check("reset", TRK, st());
        $display("reset test done");
    endtask
    task automatic t_sequence;
        step(6);
        check("trickle", TRK, st());
        @(posedge clk) cmp.above_cutoff <= 1'b1;
        step(4);
        check("bulk", BLK, st());
        @(posedge clk) cmp.at_overcharge <= 1'b1;
        step(4);
        check("overcharge", OVC, st());
        @(posedge clk) cmp.at_taper <= 1'b1;
        step(4);
        check("float", FLT, st());
        @(posedge clk) cmp <= '{1'b1, 1'b0, 1'b1, 1'b1};
        step(4);
        check("rebulk", BLK, st());
        @(posedge clk) cmp.below_float_90 <= 1'b0;
        step(6);
        check("taper ignored", BLK, st());
        $display("sequence test done");
    endtask
    task automatic t_uvlo;
        @(posedge clk) uvlo <= 1'b1;
        step(2);
        check("lockout state", TRK, st());
        check("lockout drive", 8'h00, {7'h0, drive});
        @(posedge clk) uvlo <= 1'b0;
        step(4);
        check("skip trickle", BLK, st());
        $display("lockout test done");
    endtask
    // Pulse spans the ramp climb plus three edges of comparator delay;
    // with a zero level the latch clears on the edge after each set
    task automatic t_pwm(input logic [3:0] lvl, input logic [7:0] exp_highs);
        logic [7:0] rises, highs;
        logic prev;
        rises = 8'h00;
        highs = 8'h00;
        @(posedge clk) level <= lvl;
        step(8);
        prev = drive;
        repeat (80) begin
            step(1);
            rises += {7'h0, drive && !prev};
            highs += {7'h0, drive};
            prev = drive;
        end
        check("pwm sets", 8'h0a, rises);
        check("pwm width", exp_highs, highs);
        $display("pwm test done");
    endtask
    task automatic finish_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_sequence();
        t_uvlo();
        t_pwm(4'h2, 8'h32);
        t_pwm(4'h0, 8'h0a);
        finish_test();
    end
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        $display("Error watchdog expected finish seen timeout");
        finish_test();
    end
endmodule
bind css_seq css_seq_monitor #(.PWM_PERIOD_CYC(PWM_PERIOD_CYC)) u_mon (
    .clk(clk), .srst(srst), .uvlo(uvlo), .above_cutoff(above_cutoff),
    .overcharge_voltage_threshold(overcharge_voltage_threshold),
    .below_float_90(below_float_90), .ramp_above_ctrl(ramp_above_ctrl),
    .taper_current_threshold(taper_current_threshold),
    .drive_out(drive_out), .ilim_bulk_out(ilim_bulk_out),
    .volt_reg_out(volt_reg_out), .state_code_bit0_out(state_code_bit0_out),
    .state_code_bit1_out(state_code_bit1_out),
    .low_voltage_status_out(low_voltage_status_out));
